// >>> verilog/gpio_dir_pkg.sv
/*
  constants for the general-purpose port block: register indexes, field positions,
  reset values and bus response codes.
  assumes a 32-bit axi4-lite register bus; byte address = 4 * register index.
*/
package gpio_dir_pkg;
  localparam int          NUM_PORTS      = 12;
  localparam int          NUM_BIT_PORTS  = 8;
  localparam int          NUM_GRP_PORTS  = 4;
  localparam int          PORT_W         = 4;
  // port order: zero_a, zero_b, zero_c, one_d, two_a, two_b, two_c, two_d, group a..d
  localparam logic [7:0]  IDX_DATA_FIRST = 8'h00;
  localparam logic [7:0]  IDX_DATA_LAST  = 8'h0B;
  localparam logic [7:0]  IDX_CTRL       = 8'h60;
  localparam logic [7:0]  IDX_GROUP_DIR  = 8'h67;
  localparam logic [7:0]  IDX_DIR_LAST   = 8'h68;
  localparam logic [7:0]  IDX_DIR_ZERO_A = 8'h6F;
  localparam int          CTRL_STOP_BIT  = 0;
  localparam logic [3:0]  DIR_RESET      = 4'h0;
  localparam logic [3:0]  DATA_RESET     = 4'h0;
  // port two_a bit 3 and port two_d bit 3 have no pin
  localparam logic [47:0] PIN_PRESENT    = 48'hFFFF_7FF7_FFFF;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// >>> verilog/port_cell.sv
/*
  one four-pin port: input synchroniser with standby gating, output data latch,
  and output enable from the direction bits.
  assumes pin inputs are asynchronous; all other inputs are on clk.
*/
`timescale 1ns/100ps
module port_cell (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // core side
  input  wire logic       wr_en,
  input  wire logic [3:0] wr_data,
  input  wire logic [3:0] dir,
  input  wire logic [3:0] present,
  input  wire logic       standby,
  output logic      [3:0] rd_data,
  // pins
  input  wire logic [3:0] pin_in,
  output logic      [3:0] pin_out,
  output logic      [3:0] pin_oe_n
);
  import gpio_dir_pkg::*;

  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] out_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // output latch keeps its value until the next port write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_ff <= DATA_RESET;
    end else if (wr_en) begin
      out_ff <= wr_data;
    end
  end

  assign pin_out  = out_ff;
  assign pin_oe_n = ~(dir & present);
  // inputs are cut off while the clock is stopped
  assign rd_data  = sync2_ff & present & ~{4{standby}};
endmodule // port_cell

// >>> verilog/gpio_dir.sv
/*
  general-purpose port block: direction registers, port data access and the
  clock-stop standby gate, reached over axi4-lite.
  assumes CE_RST, WDT_RST and WAKE are one-cycle pulses on CLK; pins are asynchronous.
*/
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module gpio_dir #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                RST,
  input  wire logic                WDT_RST,
  input  wire logic                CE_RST,
  input  wire logic                WAKE,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]   AWADDR,
  input  wire logic                AWVALID,
  output logic                     AWREADY,
  // axi4-lite write data
  input  wire logic [31:0]         WDATA,
  input  wire logic [3:0]          WSTRB,
  input  wire logic                WVALID,
  output logic                     WREADY,
  // axi4-lite write response
  output logic [1:0]               BRESP,
  output logic                     BVALID,
  input  wire logic                BREADY,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0]   ARADDR,
  input  wire logic                ARVALID,
  output logic                     ARREADY,
  // axi4-lite read data
  output logic [31:0]              RDATA,
  output logic [1:0]               RRESP,
  output logic                     RVALID,
  input  wire logic                RREADY,
  // pins
  input  wire logic [47:0]         PIN_IN,
  output logic      [47:0]         PIN_OUT,
  output logic      [47:0]         PIN_OE_N,
  // status
  output logic                     STANDBY
);
  import gpio_dir_pkg::*;

  if (ADDR_W < 10) begin : g_addr_w_check
    $error("ADDR_W must reach index 6FH");
  end

  logic [ADDR_W-1:0] aw_addr_ff;
  logic              aw_held_ff;
  logic [3:0]        w_data_ff;
  logic              w_strb_ff;
  logic              w_held_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [1:0]        rresp_ff;
  logic [31:0]       rdata_ff;
  logic [31:0]       bit_dir_ff;
  logic [3:0]        grp_dir_ff;
  logic              standby_ff;
  logic              do_write;
  logic [7:0]        wr_idx;
  logic [7:0]        rd_idx;
  logic [47:0]       dir_vec;
  logic [47:0]       in_vec;
  logic [NUM_PORTS-1:0] data_wr;

  // register index from a byte address
  function automatic logic [7:0] to_index(input logic [ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  // bit-wise direction slot for an index, 8 when none
  function automatic logic [3:0] dir_slot(input logic [7:0] idx);
    logic [7:0] d;
    d = IDX_DIR_ZERO_A - idx;
    if (idx >= IDX_DIR_LAST && idx <= IDX_DIR_ZERO_A) return d[3:0];
    else return 4'h8;
  endfunction

  function automatic logic is_mapped(input logic [7:0] idx);
    return (idx <= IDX_DATA_LAST) || idx == IDX_CTRL || (idx >= IDX_GROUP_DIR && idx <= IDX_DIR_ZERO_A);
  endfunction

  // write channel
  assign AWREADY  = ~aw_held_ff & ~bvalid_ff;
  assign WREADY   = ~w_held_ff & ~bvalid_ff;
  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_idx   = to_index(aw_addr_ff);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (AWVALID && AWREADY) begin
      aw_held_ff <= 1'b1;
      aw_addr_ff <= AWADDR;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      w_held_ff <= 1'b0;
      w_data_ff <= 4'h0;
      w_strb_ff <= 1'b0;
    end else if (WVALID && WREADY) begin
      w_held_ff <= 1'b1;
      w_data_ff <= WDATA[3:0];
      w_strb_ff <= WSTRB[0];
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign BVALID = bvalid_ff;
  assign BRESP  = bresp_ff;

  // direction registers; watchdog_stack_reset wins over a write, CE reset leaves them alone
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bit_dir_ff <= {NUM_BIT_PORTS{DIR_RESET}};
      grp_dir_ff <= DIR_RESET;
    end else if (WDT_RST) begin
      bit_dir_ff <= {NUM_BIT_PORTS{DIR_RESET}};
      grp_dir_ff <= DIR_RESET;
    end else if (do_write && w_strb_ff) begin
      if (dir_slot(wr_idx) < 4'h8) begin
        bit_dir_ff[dir_slot(wr_idx)*4 +: 4] <= w_data_ff;
      end else if (wr_idx == IDX_GROUP_DIR) begin
        grp_dir_ff <= w_data_ff;
      end
    end
  end

  // clock-stop standby: a stop command wins over a wake in the same cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      standby_ff <= 1'b0;
    end else if (do_write && w_strb_ff && wr_idx == IDX_CTRL && w_data_ff[CTRL_STOP_BIT]) begin
      standby_ff <= 1'b1;
    end else if (WAKE || CE_RST || WDT_RST) begin
      standby_ff <= 1'b0;
    end
  end

  assign STANDBY = standby_ff;

  // direction per pin: bit-wise ports direct, group ports replicated
  always_comb begin
    dir_vec = '0;
    for (int k = 0; k < NUM_BIT_PORTS; k++) begin
      dir_vec[k*4 +: 4] = bit_dir_ff[k*4 +: 4];
    end
    for (int g = 0; g < NUM_GRP_PORTS; g++) begin
      dir_vec[(NUM_BIT_PORTS+g)*4 +: 4] = {4{grp_dir_ff[g]}};
    end
  end

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign data_wr[p] = do_write && w_strb_ff && wr_idx == IDX_DATA_FIRST + 8'(p);
    port_cell u_cell (
      .clk      (CLK),
      .rst      (RST),
      .wr_en    (data_wr[p]),
      .wr_data  (w_data_ff),
      .dir      (dir_vec[p*4 +: 4]),
      .present  (PIN_PRESENT[p*4 +: 4]),
      .standby  (standby_ff),
      .rd_data  (in_vec[p*4 +: 4]),
      .pin_in   (PIN_IN[p*4 +: 4]),
      .pin_out  (PIN_OUT[p*4 +: 4]),
      .pin_oe_n (PIN_OE_N[p*4 +: 4])
    );
  end

  // read channel
  assign ARREADY = ~rvalid_ff;
  assign rd_idx  = to_index(ARADDR);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (ARVALID && ARREADY) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      rdata_ff  <= 32'h0000_0000;
      if (rd_idx <= IDX_DATA_LAST) begin
        rdata_ff[3:0] <= in_vec[rd_idx[3:0]*4 +: 4];
      end else if (dir_slot(rd_idx) < 4'h8) begin
        rdata_ff[3:0] <= bit_dir_ff[dir_slot(rd_idx)*4 +: 4];
      end else if (rd_idx == IDX_GROUP_DIR) begin
        rdata_ff[3:0] <= grp_dir_ff;
      end else if (rd_idx == IDX_CTRL) begin
        rdata_ff[CTRL_STOP_BIT] <= standby_ff;
      end
    end else if (RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign RVALID = rvalid_ff;
  assign RRESP  = rresp_ff;
  assign RDATA  = rdata_ff;
endmodule // gpio_dir

// >>> sim/gpio_dir_chk.sv
/* port checks for gpio_dir.
   bound to gpio_dir; sees its ports only. */
`timescale 1ns/100ps
module gpio_dir_chk (
  // clock and resets
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        WDT_RST,
  input wire logic        CE_RST,
  input wire logic        WAKE,
  // bus
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        RVALID,
  input wire logic [31:0] RDATA,
  // pins and status
  input wire logic [47:0] PIN_OE_N,
  input wire logic        STANDBY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  chk_wr_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write not answered");
  chk_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  chk_rd_width: assert property (RVALID |-> RDATA[31:4] == 28'h0)
    else $error("read data above bit 3");
  chk_no_pin: assert property (PIN_OE_N[19] && PIN_OE_N[31])
    else $error("absent pin enabled");
  chk_dir_cause: assert property ($changed(PIN_OE_N) |-> $rose(BVALID) || $past(WDT_RST))
    else $error("direction changed without cause");
  chk_wdt_clear: assert property (WDT_RST |=> &PIN_OE_N)
    else $error("direction kept over watchdog reset");
  chk_ce_keep: assert property (CE_RST |=> $stable(PIN_OE_N) || $rose(BVALID))
    else $error("direction lost at ce reset");
  chk_wake_clear: assert property (WAKE |=> !STANDBY || $rose(BVALID))
    else $error("standby kept after wake");
  cover property (WDT_RST);
  cover property ($rose(STANDBY));
  cover property (BVALID && BRESP == 2'h2);
endmodule // gpio_dir_chk
bind gpio_dir gpio_dir_chk gpio_dir_chk_i (.*);

// >>> sim/pin_board.sv
/* board on the port pins: driven pins read back, others see a pattern.
   assumes pat is held steady by the bench. */
`timescale 1ns/100ps
module pin_board (
  // from bench
  input  wire logic [47:0] pat,
  // pins
  input  wire logic [47:0] PIN_OUT,
  input  wire logic [47:0] PIN_OE_N,
  output logic      [47:0] PIN_IN
);
  assign PIN_IN = (PIN_OUT & ~PIN_OE_N) | (pat & PIN_OE_N);
endmodule // pin_board

// >>> sim/gpio_dir_tb.sv
/* self-checking bench for gpio_dir.
   assumes pin_board and the bound checker are compiled with it. */
`timescale 1ns/100ps
module gpio_dir_tb;
  logic        CLK = 1'h0, RST = 1'h1, WDT_RST = 1'h0, CE_RST = 1'h0, WAKE = 1'h0;
  logic        AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  logic [11:0] AWADDR = 12'h0, ARADDR = 12'h0;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic [3:0]  WSTRB = 4'hF;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, STANDBY;
  logic [1:0]  BRESP, RRESP;
  logic [47:0] PIN_IN, PIN_OUT, PIN_OE_N, pat = 48'h5A5A_5A5A_5A52;
  int          err_count = 0, compares = 0;
  gpio_dir gpio_dir_i (.*);
  pin_board pin_board_i (.*);
  initial forever #25 CLK = ~CLK;
  task automatic cmp(input logic [47:0] g, input logic [47:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one bus transfer: w=1 write, else read; d is write data or expected read data
  task automatic xfer(input bit w, input logic [7:0] i, input logic [3:0] d, input logic [1:0] er);
    int n;
    bit a, b, r, ok, bv;
    @(posedge CLK);
    if (w) begin
      AWADDR <= {2'h0, i, 2'h0};
      WDATA <= {28'h0, d};
      AWVALID <= 1'h1;
      WVALID <= 1'h1;
    end else begin
      ARADDR <= {2'h0, i, 2'h0};
      ARVALID <= 1'h1;
      RREADY <= 1'h1;
    end
    for (n = 0; n < 40; n++) begin
      @(negedge CLK);
      a = w & AWVALID & AWREADY;
      b = w & WVALID & WREADY;
      r = !w & ARVALID & ARREADY;
      ok = w ? BVALID & BREADY : RVALID;
      bv = w & BVALID;
      if (ok) cmp(w ? BRESP : RRESP, er);
      if (ok && !w) cmp(RDATA, d);
      @(posedge CLK);
      if (a) AWVALID <= 1'h0;
      if (b) WVALID <= 1'h0;
      if (r) ARVALID <= 1'h0;
      if (ok) begin
        BREADY <= 1'h0;
        RREADY <= 1'h0;
        break;
      end
      // response accepted only after it has been seen, so it must stand meanwhile
      if (bv) BREADY <= 1'h1;
    end
    if (n == 40) begin
      err_count++;
      print_verdict;
    end
  endtask
  task automatic t_reset;
    cmp(PIN_OE_N, 48'hFFFF_FFFF_FFFF);
    xfer(1'h0, 8'h6F, 4'h0, 2'h0);
  endtask
  task automatic t_bit_dir;
    xfer(1'h1, 8'h6F, 4'h5, 2'h0);
    cmp(PIN_OE_N[7:0], 8'hFA);
    xfer(1'h0, 8'h6F, 4'h5, 2'h0);
    xfer(1'h1, 8'h00, 4'hF, 2'h0);
    cmp(PIN_OUT[3:0], 4'hF);
    repeat (3) @(posedge CLK);
    xfer(1'h0, 8'h00, 4'h7, 2'h0);
  endtask
  task automatic t_group;
    xfer(1'h1, 8'h67, 4'h2, 2'h0);
    cmp(PIN_OE_N[47:32], 16'hFF0F);
    xfer(1'h1, 8'h6B, 4'hF, 2'h0);
    xfer(1'h1, 8'h68, 4'hF, 2'h0);
    cmp(PIN_OE_N[31:16], 16'h8FF8);
    xfer(1'h0, 8'h6B, 4'hF, 2'h0);
  endtask
  task automatic t_stop;
    xfer(1'h1, 8'h60, 4'h1, 2'h0);
    cmp(STANDBY, 1'h1);
    xfer(1'h0, 8'h00, 4'h0, 2'h0);
    @(posedge CLK) CE_RST <= 1'h1;
    @(posedge CLK) CE_RST <= 1'h0;
    @(negedge CLK) cmp(STANDBY, 1'h0);
    cmp(PIN_OE_N[3:0], 4'hA);
    xfer(1'h1, 8'h60, 4'h1, 2'h0);
    @(posedge CLK) WAKE <= 1'h1;
    @(posedge CLK) WAKE <= 1'h0;
    @(negedge CLK) cmp(STANDBY, 1'h0);
    @(posedge CLK) WDT_RST <= 1'h1;
    @(posedge CLK) WDT_RST <= 1'h0;
    @(negedge CLK) cmp(PIN_OE_N, 48'hFFFF_FFFF_FFFF);
    xfer(1'h0, 8'h6F, 4'h0, 2'h0);
    WSTRB <= 4'h0;
    xfer(1'h1, 8'h6F, 4'hF, 2'h0);
    WSTRB <= 4'hF;
    xfer(1'h0, 8'h6F, 4'h0, 2'h0);
  endtask
  initial begin
    repeat (10) @(posedge CLK);
    RST <= 1'h0;
    t_reset;
    t_bit_dir;
    t_group;
    t_stop;
    xfer(1'h1, 8'h10, 4'h5, 2'h2);
    xfer(1'h0, 8'h10, 4'h0, 2'h2);
    print_verdict;
  end
endmodule // gpio_dir_tb
